// >>> cawdu_core.sv
// addressing, fetch wait and dual data pointer unit with ahb-lite registers
//
// The AHB-Lite slave port is this design's own decision.
module cawdu_core (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ta_open,
    input  wire logic        fetch_start,
    output logic             fetch_busy,
    output logic             fetch_done,
    input  wire logic [19:0] pc_value,
    output logic [19:0]      prog_addr,
    output logic [15:0]      stack_addr,
    output logic             stack_mode_indicator,
    output logic             vector_base_select,
    input  wire logic        first_data_pointer_inc,
    input  wire logic        first_data_pointer_use,
    input  wire logic        movx_ri,
    input  wire logic [7:0]  ri_value,
    input  wire logic [7:0]  port_two_latch,
    output logic [23:0]      external_ram_address
);
    logic [7:0]  pointer_select_reg;
    logic [3:0]  fetch_wait_field;
    logic [7:0]  addr_mode_reg;
    logic [7:0]  xram_base_field;
    logic [7:0]  indirect_high_byte;
    logic [7:0]  indirect_top_byte;
    logic [23:0] first_data_pointer;
    logic [23:0] second_data_pointer;
    logic [15:0] stack_reg;
    logic [4:0]  wait_cnt_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [9:0]  idx_reg;
    logic [31:0] hrdata_reg;
    logic [23:0] xaddr_reg;
    logic        flat;
    logic        sel;
    logic        bus_wr;
    logic        addr_phase;
    logic [31:0] rd_mux;
    logic [23:0] xbase_off;

    function automatic logic [23:0] step(input logic [23:0] v,
                                         input logic dec,
                                         input logic full);
        logic [23:0] r;
        r = dec ? v - 24'h000001 : v + 24'h000001;
        step = full ? r : {v[23:16], r[15:0]};
    endfunction

    function automatic logic wr_to(input logic [9:0] i, input logic [9:0] t);
        wr_to = (i == t);
    endfunction

    assign flat = addr_mode_reg[cawdu_pkg::AM_HI_BIT];
    assign sel  = pointer_select_reg[cawdu_pkg::SEL_BIT];
    assign stack_mode_indicator = flat;
    assign vector_base_select = addr_mode_reg[cawdu_pkg::VSEL_BIT];
    assign prog_addr = flat ? pc_value : {4'h0, pc_value[15:0]};
    assign stack_addr = flat ? stack_reg : {8'h00, stack_reg[7:0]};
    assign external_ram_address = xaddr_reg;
    assign xbase_off = {4'h0, xram_base_field, 12'h000};
    assign hreadyout = !rd_pend_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign addr_phase = hsel && htrans[1] && hready;
    assign bus_wr = wr_pend_reg;
    assign fetch_busy = (wait_cnt_reg != 5'h00);
    assign fetch_done = (wait_cnt_reg == 5'h01);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx_reg)
            cawdu_pkg::IDX_PTR_SEL: rd_mux[7:0] = pointer_select_reg;
            cawdu_pkg::IDX_FETCH:   rd_mux[3:0] = fetch_wait_field;
            cawdu_pkg::IDX_MODE: begin
                rd_mux[7:0] = addr_mode_reg;
                rd_mux[cawdu_pkg::STK_IND_BIT] = flat;
            end
            cawdu_pkg::IDX_XBASE:   rd_mux[7:0] = xram_base_field;
            cawdu_pkg::IDX_IND_HI:  rd_mux[7:0] = indirect_high_byte;
            cawdu_pkg::IDX_IND_TOP: rd_mux[7:0] = indirect_top_byte;
            cawdu_pkg::IDX_PTR0:    rd_mux[23:0] = first_data_pointer;
            cawdu_pkg::IDX_PTR1:    rd_mux[23:0] = second_data_pointer;
            cawdu_pkg::IDX_STACK:   rd_mux[15:0] = stack_reg;
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // bus phases: writes finish in one data cycle, reads take one wait
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 10'h000;
            hrdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_reg <= addr_phase && hwrite;
            rd_pend_reg <= addr_phase && !hwrite;
            if (addr_phase)
                idx_reg <= haddr[11:2];
            if (rd_pend_reg)
                hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fetch_wait_field <= cawdu_pkg::RST_FETCH;
            indirect_high_byte <= 8'h00;
            indirect_top_byte <= 8'h00;
            stack_reg <= 16'h0000;
        end else if (ce && bus_wr) begin
            if (wr_to(idx_reg, cawdu_pkg::IDX_FETCH))
                fetch_wait_field <= hwdata[3:0];
            if (wr_to(idx_reg, cawdu_pkg::IDX_IND_HI))
                indirect_high_byte <= hwdata[7:0];
            if (wr_to(idx_reg, cawdu_pkg::IDX_IND_TOP))
                indirect_top_byte <= hwdata[7:0];
            if (wr_to(idx_reg, cawdu_pkg::IDX_STACK))
                stack_reg <= hwdata[15:0];
        end
    end

    // protected registers accept writes only while timed access is open
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_mode_reg <= cawdu_pkg::RST_MODE;
            xram_base_field <= cawdu_pkg::RST_XBASE;
        end else if (ce && bus_wr && ta_open) begin
            if (wr_to(idx_reg, cawdu_pkg::IDX_MODE))
                addr_mode_reg <= hwdata[7:0] & cawdu_pkg::MODE_WR_MASK;
            if (wr_to(idx_reg, cawdu_pkg::IDX_XBASE))
                xram_base_field <= hwdata[7:0];
        end
    end

    // select bit: a bus write wins over a toggle in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pointer_select_reg <= cawdu_pkg::RST_PTR_SEL;
        end else if (ce) begin
            if (bus_wr && wr_to(idx_reg, cawdu_pkg::IDX_PTR_SEL))
                pointer_select_reg <= hwdata[7:0] & cawdu_pkg::SEL_WR_MASK;
            else if (first_data_pointer_use && pointer_select_reg[cawdu_pkg::TOGGLE_BIT])
                pointer_select_reg[cawdu_pkg::SEL_BIT] <= !sel;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            first_data_pointer <= 24'h000000;
            second_data_pointer <= 24'h000000;
        end else if (ce) begin
            if (bus_wr && wr_to(idx_reg, cawdu_pkg::IDX_PTR0))
                first_data_pointer <= hwdata[23:0];
            else if (first_data_pointer_inc && !sel)
                first_data_pointer <= step(first_data_pointer,
                    pointer_select_reg[cawdu_pkg::DIR_LO_BIT],
                    flat);
            if (bus_wr && wr_to(idx_reg, cawdu_pkg::IDX_PTR1))
                second_data_pointer <= hwdata[23:0];
            else if (first_data_pointer_inc && sel)
                second_data_pointer <= step(second_data_pointer,
                    pointer_select_reg[cawdu_pkg::DIR_HI_BIT],
                    flat);
        end
    end

    // xram address, relocated by the base field in 4KB steps
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            xaddr_reg <= 24'h000000;
        end else if (ce) begin
            if (movx_ri)
                xaddr_reg <= {indirect_top_byte,
                    addr_mode_reg[cawdu_pkg::HSRC_BIT] ? indirect_high_byte
                        : port_two_latch, ri_value}
                    + xbase_off;
            else
                xaddr_reg <= (sel ? second_data_pointer : first_data_pointer)
                    + xbase_off;
        end
    end

    // program fetch stretch; data moves never load this counter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_cnt_reg <= 5'h00;
        end else if (ce) begin
            if (fetch_start && !fetch_busy)
                wait_cnt_reg <= {1'b0, fetch_wait_field} + 5'h01;
            else if (fetch_busy)
                wait_cnt_reg <= wait_cnt_reg - 5'h01;
        end
    end

    logic [4:0] elapsed_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            elapsed_reg <= 5'h00;
        else if (ce && fetch_start && !fetch_busy)
            elapsed_reg <= 5'h01;
        else if (ce && fetch_busy)
            elapsed_reg <= elapsed_reg + 5'h01;
    end

    property p_fetch_len;
        @(posedge clk_sys) disable iff (reset)
        fetch_done |-> elapsed_reg == {1'b0, fetch_wait_field} + 5'h01;
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("fetch stretch length wrong");

    property p_fetch_refuse;
        @(posedge clk_sys) disable iff (reset)
        ce && fetch_start && fetch_busy |=>
            wait_cnt_reg == $past(wait_cnt_reg) - 5'h01;
    endproperty
    a_fetch_refuse: assert property (p_fetch_refuse)
        else $error("fetch start accepted while busy");

    property p_fetch_rst;
        @(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> fetch_wait_field == cawdu_pkg::RST_FETCH;
    endproperty
    a_fetch_rst: assert property (p_fetch_rst)
        else $error("fetch wait reset value wrong");

    property p_prog;
        @(posedge clk_sys) disable iff (reset)
        !addr_mode_reg[1] |-> prog_addr[19:16] == 4'h0;
    endproperty
    a_prog: assert property (p_prog)
        else $error("large mode program address exceeds 16 bits");

    property p_stk_ind;
        @(posedge clk_sys) disable iff (reset)
        ce && rd_pend_reg && idx_reg == cawdu_pkg::IDX_MODE |=>
            hrdata[cawdu_pkg::STK_IND_BIT] == $past(flat);
    endproperty
    a_stk_ind: assert property (p_stk_ind)
        else $error("stack indicator reads wrong");

    property p_stack;
        @(posedge clk_sys) disable iff (reset)
        !flat |-> stack_addr[15:8] == 8'h00;
    endproperty
    a_stack: assert property (p_stack)
        else $error("large mode stack address has upper byte");

    property p_ri;
        @(posedge clk_sys) disable iff (reset)
        ce && movx_ri && xram_base_field == 8'h00 |=>
            external_ram_address[7:0] == $past(ri_value) &&
            external_ram_address[23:16] == $past(indirect_top_byte);
    endproperty
    a_ri: assert property (p_ri)
        else $error("indirect move address wrong");

    property p_toggle;
        @(posedge clk_sys) disable iff (reset)
        ce && first_data_pointer_use && pointer_select_reg[cawdu_pkg::TOGGLE_BIT]
            && !bus_wr |=> sel != $past(sel);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pointer select did not toggle");

    property p_ta;
        @(posedge clk_sys) disable iff (reset)
        !ta_open |=> $stable(addr_mode_reg) && $stable(xram_base_field);
    endproperty
    a_ta: assert property (p_ta)
        else $error("protected register changed while locked");

    property p_large_top;
        @(posedge clk_sys) disable iff (reset)
        ce && first_data_pointer_inc && !sel && !flat && !bus_wr |=>
            first_data_pointer[23:16] == $past(first_data_pointer[23:16]);
    endproperty
    a_large_top: assert property (p_large_top)
        else $error("large mode top byte changed");

    c_fetch: cover property (@(posedge clk_sys) disable iff (reset)
        fetch_done && fetch_wait_field == 4'hf);
    c_toggle: cover property (@(posedge clk_sys) disable iff (reset)
        ce && first_data_pointer_use && pointer_select_reg[5]);
    c_flat: cover property (@(posedge clk_sys) disable iff (reset)
        flat && first_data_pointer_inc);
    c_ri: cover property (@(posedge clk_sys) disable iff (reset)
        movx_ri && addr_mode_reg[cawdu_pkg::HSRC_BIT]);
endmodule // cawdu_core

// >>> cawdu_mem_model.sv
// flash stand-in that latches the program address of each completed fetch
module cawdu_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        fetch_done,
    input  wire logic [19:0] prog_addr,
    output logic      [19:0] fetch_addr_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    initial fetch_addr_seen = 20'h00000;
    // the flash answers only at the end of a stretched fetch
    always @(posedge clk_sys) begin
        if (fetch_done === 1'b1) begin
            fetch_addr_seen <= prog_addr;
        end
    end
endmodule // cawdu_mem_model

// >>> cawdu_pkg.sv
// constants and register map of the addressing and pointer unit
// Contract
// - only program fetches stretch, by wait field plus one: 1 to 16
// - fetch wait register resets to 0x07, eight wait cycles
// - xram base comes from relocation register in 4KB steps
// - large: 16-bit program; flat: 20-bit program, 16-bit stack
// - mode field 00 selects large, upper bit set selects flat
// - read-only stack indicator: 0 internal, 1 extended 16-bit stack
// - indirect moves take bits 15..8 from port latch or high byte reg
// - indirect top byte drives bits 23..16 for indirect moves only
// - pointer moves use selected pointer's top, high and low bytes
// - select bit picks second pointer when set; reads current choice
// - direction bits choose increment or decrement per pointer
// - with toggle enabled, select inverts when a pointer is used
// - flat mode stack address is upper stack byte over stack pointer
// - flat mode pointers count as 24-bit; large keeps top byte
package cawdu_pkg;
    localparam logic [9:0] IDX_PTR_SEL   = 10'h086;
    localparam logic [9:0] IDX_FETCH     = 10'h092;
    localparam logic [9:0] IDX_MODE      = 10'h09d;
    localparam logic [9:0] IDX_XBASE     = 10'h0c6;
    localparam logic [9:0] IDX_IND_HI    = 10'h0da;
    localparam logic [9:0] IDX_IND_TOP   = 10'h0ea;
    localparam logic [9:0] IDX_PTR0      = 10'h100;
    localparam logic [9:0] IDX_PTR1      = 10'h101;
    localparam logic [9:0] IDX_STACK     = 10'h102;
    localparam logic [7:0] RST_PTR_SEL   = 8'h00;
    localparam logic [3:0] RST_FETCH     = 4'h7;
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [7:0] RST_XBASE     = 8'h00;
    localparam int SEL_BIT    = 0;
    localparam int TOGGLE_BIT = 5;
    localparam int DIR_LO_BIT = 6;
    localparam int DIR_HI_BIT = 7;
    localparam int AM_LO_BIT  = 0;
    localparam int AM_HI_BIT  = 1;
    localparam int STK_IND_BIT = 2;
    localparam int HSRC_BIT   = 3;
    localparam int VSEL_BIT   = 5;
    localparam logic [7:0] MODE_WR_MASK = 8'h2b;
    localparam logic [7:0] SEL_WR_MASK  = 8'he1;
    localparam int XBASE_SHIFT = 12;
endpackage

// >>> cpu_addressing_wait_first_data_pointer_unit_tb.sv
// self-checking bench for the addressing, fetch wait and pointer unit
module cpu_addressing_wait_first_data_pointer_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, reset = 1, ce = 1, hsel = 0, hwrite = 0;
    logic        ta_open = 0, fetch_start = 0, first_data_pointer_inc = 0, first_data_pointer_use = 0;
    logic        movx_ri = 1, hreadyout, hresp, fetch_busy, fetch_done;
    logic        stack_mode_indicator, vector_base_select;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rdat;
    logic [7:0]  ri_value = 8'h78, port_two_latch = 8'h56;
    logic [19:0] pc_value = 20'habcde, prog_addr, fetch_addr_seen;
    logic [15:0] stack_addr;
    logic [23:0] external_ram_address;
    wire logic   hready = hreadyout;
    int          miscompares = 0, compares = 0;
    localparam logic [9:0] RIDX [7] = '{cawdu_pkg::IDX_PTR_SEL,
        cawdu_pkg::IDX_FETCH, cawdu_pkg::IDX_MODE, cawdu_pkg::IDX_XBASE,
        cawdu_pkg::IDX_IND_HI, cawdu_pkg::IDX_IND_TOP, 10'h050};

    cawdu_core u_cawdu_core (.clk_sys, .reset, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .ta_open, .fetch_start, .fetch_busy, .fetch_done, .pc_value,
        .prog_addr, .stack_addr, .stack_mode_indicator, .vector_base_select,
        .first_data_pointer_inc, .first_data_pointer_use, .movx_ri, .ri_value, .port_two_latch,
        .external_ram_address);
    cawdu_mem_model u_cawdu_mem_model (.clk_sys, .fetch_done, .prog_addr,
        .fetch_addr_seen);

    always #4 clk_sys = ~clk_sys;

    task automatic summarize;
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask

    // ready is judged as sampled at the rising edge that ends the phase
    task automatic wait_rdy;
        logic ok;
        int   n;
        n = 0;
        do begin
            @(negedge clk_sys);
            ok = hreadyout;
            rdat = hrdata;
            @(posedge clk_sys);
            n++;
        end while (ok !== 1'b1 && n < 20);
        if (ok !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic pulse(input int which);
        if (which == 0) fetch_start <= 1'b1;
        else if (which == 1) first_data_pointer_inc <= 1'b1;
        else first_data_pointer_use <= 1'b1;
        @(posedge clk_sys);
        fetch_start <= 1'b0;
        first_data_pointer_inc <= 1'b0;
        first_data_pointer_use <= 1'b0;
    endtask

    task automatic fetch(input logic [3:0] f, input logic [19:0] a);
        int n;
        pulse(0);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (fetch_done !== 1'b1 && n < 40);
        if (fetch_done !== 1'b1) begin
            miscompares++;
            summarize();
        end
        chk("fetch wait", 32'(f) + 1, 32'(n));
        chk("fetch busy", 32'h1, 32'(fetch_busy));
        @(negedge clk_sys);
        chk("fetch idle", 32'h0, 32'(fetch_busy));
        chk("fetch addr", 32'(a), 32'(fetch_addr_seen));
        @(posedge clk_sys);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        logic [1:0] d;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (RIDX[i]) begin
            bus(1'b0, RIDX[i], 32'h0);
            chk("reset value", (i == 1) ? 32'h07 : 32'h00, rdat);
        end
        chk("hresp", 32'h0, 32'(hresp));
        fetch(4'h7, 20'h0bcde);
        for (int f = 0; f < 16; f += 15) begin
            bus(1'b1, cawdu_pkg::IDX_FETCH, 32'(f));
            fetch(4'(f), 20'h0bcde);
        end
        bus(1'b1, cawdu_pkg::IDX_FETCH, 32'hff);
        bus(1'b0, cawdu_pkg::IDX_FETCH, 32'h0);
        chk("fetch reg", 32'h0f, rdat);
        bus(1'b1, cawdu_pkg::IDX_MODE, 32'h02);
        bus(1'b0, cawdu_pkg::IDX_MODE, 32'h0);
        chk("locked mode", 32'h00, rdat);
        ta_open <= 1'b1;
        bus(1'b1, cawdu_pkg::IDX_STACK, 32'h5a3c);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, cawdu_pkg::IDX_MODE, 32'(m));
            bus(1'b0, cawdu_pkg::IDX_MODE, 32'h0);
            chk("mode", 32'(m) | (m[1] ? 32'h4 : 32'h0), rdat);
            chk("indicator", 32'(m[1]), 32'(stack_mode_indicator));
            chk("prog", m[1] ? 32'habcde : 32'h0bcde, 32'(prog_addr));
            chk("stack", m[1] ? 32'h5a3c : 32'h3c, 32'(stack_addr));
        end
        fetch(4'hf, 20'habcde);
        bus(1'b1, cawdu_pkg::IDX_MODE, 32'h20);
        bus(1'b1, cawdu_pkg::IDX_IND_HI, 32'h12);
        bus(1'b1, cawdu_pkg::IDX_IND_TOP, 32'h34);
        settle();
        chk("vector", 32'h1, 32'(vector_base_select));
        chk("ri port", 32'h345678, 32'(external_ram_address));
        bus(1'b1, cawdu_pkg::IDX_MODE, 32'h28);
        settle();
        chk("ri high", 32'h341278, 32'(external_ram_address));
        bus(1'b1, cawdu_pkg::IDX_XBASE, 32'h01);
        settle();
        chk("ri base", 32'h342278, 32'(external_ram_address));
        ta_open <= 1'b0;
        bus(1'b1, cawdu_pkg::IDX_XBASE, 32'h00);
        bus(1'b0, cawdu_pkg::IDX_XBASE, 32'h0);
        chk("locked base", 32'h01, rdat);
        ta_open <= 1'b1;
        bus(1'b1, cawdu_pkg::IDX_XBASE, 32'h00);
        bus(1'b1, cawdu_pkg::IDX_MODE, 32'h02);
        movx_ri <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = 2'(i);
            bus(1'b1, cawdu_pkg::IDX_PTR0, 32'h01ffff);
            bus(1'b1, cawdu_pkg::IDX_PTR1, 32'h020000);
            bus(1'b1, cawdu_pkg::IDX_PTR_SEL, {24'h0, d, 6'h00});
            settle();
            chk("ptr0 addr", 32'h01ffff, 32'(external_ram_address));
            pulse(1);
            bus(1'b1, cawdu_pkg::IDX_PTR_SEL, {24'h0, d, 6'h01});
            settle();
            chk("ptr1 addr", 32'h020000, 32'(external_ram_address));
            pulse(1);
            bus(1'b0, cawdu_pkg::IDX_PTR0, 32'h0);
            chk("ptr0", d[0] ? 32'h01fffe : 32'h020000, rdat);
            bus(1'b0, cawdu_pkg::IDX_PTR1, 32'h0);
            chk("ptr1", d[1] ? 32'h01ffff : 32'h020001, rdat);
        end
        bus(1'b1, cawdu_pkg::IDX_MODE, 32'h00);
        bus(1'b1, cawdu_pkg::IDX_PTR0, 32'h01ffff);
        bus(1'b1, cawdu_pkg::IDX_PTR_SEL, 32'h00);
        pulse(1);
        bus(1'b0, cawdu_pkg::IDX_PTR0, 32'h0);
        chk("ptr0 large", 32'h010000, rdat);
        bus(1'b1, cawdu_pkg::IDX_PTR_SEL, 32'h20);
        pulse(2);
        bus(1'b0, cawdu_pkg::IDX_PTR_SEL, 32'h0);
        chk("toggle", 32'h21, rdat);
        pulse(2);
        bus(1'b0, cawdu_pkg::IDX_PTR_SEL, 32'h0);
        chk("toggle back", 32'h20, rdat);
        bus(1'b1, cawdu_pkg::IDX_PTR_SEL, 32'hff);
        bus(1'b0, cawdu_pkg::IDX_PTR_SEL, 32'h0);
        chk("select", 32'he1, rdat);
        summarize();
    end
endmodule // cpu_addressing_wait_first_data_pointer_unit_tb
